//--- logic/debug_port_pkg.sv
// Constants and types shared by the debug port address-select block
`default_nettype none

package debug_port_pkg;

  // --------------------------------------------------------------
  // Selector codes
  // --------------------------------------------------------------
  localparam logic [7:0] SEL_PART_ID    = 8'h00;
  localparam logic [7:0] SEL_REV_ID     = 8'h01;
  localparam logic [7:0] SEL_HALT_CTL   = 8'h02;
  localparam logic [7:0] SEL_PROG_CTL   = 8'hdf;
  localparam logic [7:0] SEL_PROM_DATA  = 8'hbf;
  localparam logic [7:0] SEL_PROM_STAT  = 8'hb7;
  localparam logic [7:0] SEL_ADDR_HI    = 8'haf;
  localparam logic [7:0] SEL_ADDR_LO    = 8'hae;
  localparam logic [7:0] SEL_CKSUM_0    = 8'ha9;
  localparam logic [7:0] SEL_CKSUM_1    = 8'haa;
  localparam logic [7:0] SEL_CKSUM_2    = 8'hab;
  localparam logic [7:0] SEL_CKSUM_3    = 8'hac;
  localparam logic [7:0] SELECTOR_RESET = 8'h00;

  // --------------------------------------------------------------
  // Identification values (arbitrary values)
  // --------------------------------------------------------------
  localparam logic [7:0] PART_ID_VALUE = 8'h5a;
  localparam logic [7:0] REV_ID_VALUE  = 8'h00;

  // --------------------------------------------------------------
  // Frame layout
  // --------------------------------------------------------------
  localparam logic [1:0] INS_DATA_READ  = 2'h0;
  localparam logic [1:0] INS_DATA_WRITE = 2'h1;
  localparam logic [1:0] INS_ADDR_READ  = 2'h2;
  localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
  localparam logic [3:0] INS_BITS       = 4'h2;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam int         BUSY_BIT       = 7;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    TGT_NONE      = 4'h0,
    TGT_PART_ID   = 4'h1,
    TGT_REV_ID    = 4'h2,
    TGT_HALT_CTL  = 4'h3,
    TGT_PROG_CTL  = 4'h4,
    TGT_PROM_DATA = 4'h5,
    TGT_PROM_STAT = 4'h6,
    TGT_ADDR_HI   = 4'h7,
    TGT_ADDR_LO   = 4'h8,
    TGT_CKSUM_0   = 4'h9,
    TGT_CKSUM_1   = 4'ha,
    TGT_CKSUM_2   = 4'hb,
    TGT_CKSUM_3   = 4'hc
  } target_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_INS   = 2'h1,
    ST_WDATA = 2'h2,
    ST_RDATA = 2'h3
  } frame_state_t;

  typedef struct packed {
    target_t    target;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } data_cmd_t;

endpackage

`default_nettype wire

//--- logic/debug_port_address_select.sv
// Address-select register and data routing of the two-wire debug port
`default_nettype none

// Function
// - Selector is written by the programmer; later data commands go to its target.
// - 0x00 part id, 0x01 revision id; both read only, writes ignored.
// - 0x02 halt control, 0xDF program control, 0xBF memory data.
// - 0xB7 program status, 0xAF address high, 0xAE address low.
// - 0xA9 to 0xAC select checksum bytes zero to three in order.
// - Selector read returns status; bit 7 high while a memory operation runs.
// - Two pins only: bidirectional data and a programmer-driven clock.
module debug_port_address_select #(
  parameter logic [7:0] part_id_value = debug_port_pkg::PART_ID_VALUE,
  parameter logic [7:0] rev_id_value  = debug_port_pkg::REV_ID_VALUE
) (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic                      debug_clock_pin,
  input  wire logic                      debug_data_pin_in,
  input  wire logic                      prog_busy,
  input  wire logic [7:0]                device_rdata,
  output logic                           debug_data_pin_out,
  output logic                           debug_data_pin_oe,
  output logic [7:0]                     debug_register_selector,
  output debug_port_pkg::data_cmd_t      data_cmd
);

  // --------------------------------------------------------------
  // Target decode
  // --------------------------------------------------------------
  function automatic debug_port_pkg::target_t decode_target(input logic [7:0] sel);
    unique case (sel)
      debug_port_pkg::SEL_PART_ID:   decode_target = debug_port_pkg::TGT_PART_ID;
      debug_port_pkg::SEL_REV_ID:    decode_target = debug_port_pkg::TGT_REV_ID;
      debug_port_pkg::SEL_HALT_CTL:  decode_target = debug_port_pkg::TGT_HALT_CTL;
      debug_port_pkg::SEL_PROG_CTL:  decode_target = debug_port_pkg::TGT_PROG_CTL;
      debug_port_pkg::SEL_PROM_DATA: decode_target = debug_port_pkg::TGT_PROM_DATA;
      debug_port_pkg::SEL_PROM_STAT: decode_target = debug_port_pkg::TGT_PROM_STAT;
      debug_port_pkg::SEL_ADDR_HI:   decode_target = debug_port_pkg::TGT_ADDR_HI;
      debug_port_pkg::SEL_ADDR_LO:   decode_target = debug_port_pkg::TGT_ADDR_LO;
      debug_port_pkg::SEL_CKSUM_0:   decode_target = debug_port_pkg::TGT_CKSUM_0;
      debug_port_pkg::SEL_CKSUM_1:   decode_target = debug_port_pkg::TGT_CKSUM_1;
      debug_port_pkg::SEL_CKSUM_2:   decode_target = debug_port_pkg::TGT_CKSUM_2;
      debug_port_pkg::SEL_CKSUM_3:   decode_target = debug_port_pkg::TGT_CKSUM_3;
      default:                       decode_target = debug_port_pkg::TGT_NONE;
    endcase
  endfunction

  function automatic logic is_external(input debug_port_pkg::target_t t);
    is_external = (t != debug_port_pkg::TGT_NONE) && (t != debug_port_pkg::TGT_PART_ID) &&
                  (t != debug_port_pkg::TGT_REV_ID);
  endfunction

  // --------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // --------------------------------------------------------------
  // Pin synchronisers and link clock edges
  // --------------------------------------------------------------
  logic ck_meta;
  logic ck_sync;
  logic ck_prev;
  logic dt_meta;
  logic dt_sync;
  logic ck_rise;
  logic ck_fall;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_prev <= 1'b0;
      dt_meta <= 1'b0;
      dt_sync <= 1'b0;
    end else begin
      ck_meta <= debug_clock_pin;
      ck_sync <= ck_meta;
      ck_prev <= ck_sync;
      dt_meta <= debug_data_pin_in;
      dt_sync <= dt_meta;
    end
  end

  assign ck_rise = ck_sync & ~ck_prev;
  assign ck_fall = ~ck_sync & ck_prev;

  // --------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------
  debug_port_pkg::frame_state_t state;
  debug_port_pkg::frame_state_t next_state;
  logic [3:0]                   cnt;
  logic [3:0]                   next_cnt;
  logic [1:0]                   ins;
  logic [1:0]                   next_ins;
  logic [7:0]                   shift;
  logic [7:0]                   next_shift;
  logic                         load_ext;
  logic                         next_load_ext;
  logic [7:0]                   next_selector;
  debug_port_pkg::data_cmd_t    next_cmd;
  logic                         next_out;
  logic                         next_oe;

  always_comb begin
    logic [7:0] word;
    word          = {dt_sync, shift[7:1]};
    next_state    = state;
    next_cnt      = cnt;
    next_ins      = ins;
    next_shift    = shift;
    next_load_ext = load_ext;
    next_selector = debug_register_selector;
    next_cmd      = data_cmd;
    next_cmd.wr   = 1'b0;
    next_cmd.rd   = 1'b0;
    next_out      = debug_data_pin_out;
    next_oe       = debug_data_pin_oe;
    unique case (state)
      debug_port_pkg::ST_IDLE: begin
        if (ck_rise && dt_sync) begin
          next_state = debug_port_pkg::ST_INS;
          next_cnt   = 4'h0;
        end
      end
      debug_port_pkg::ST_INS: begin
        if (ck_rise) begin
          next_ins = {dt_sync, ins[1]};
          next_cnt = cnt + 4'h1;
          if (cnt == debug_port_pkg::INS_BITS - 4'h1) begin
            next_cnt      = 4'h0;
            next_load_ext = 1'b0;
            unique case (next_ins)
              debug_port_pkg::INS_ADDR_READ: begin
                next_shift                          = 8'h00;
                next_shift[debug_port_pkg::BUSY_BIT] = prog_busy;
                next_state                          = debug_port_pkg::ST_RDATA;
              end
              debug_port_pkg::INS_DATA_READ: begin
                next_state = debug_port_pkg::ST_RDATA;
                if (data_cmd.target == debug_port_pkg::TGT_PART_ID) begin
                  next_shift = part_id_value;
                end else if (data_cmd.target == debug_port_pkg::TGT_REV_ID) begin
                  next_shift = rev_id_value;
                end else if (is_external(data_cmd.target)) begin
                  next_cmd.rd   = 1'b1;
                  next_load_ext = 1'b1;
                end else begin
                  next_shift = 8'h00;
                end
              end
              default: begin
                next_state = debug_port_pkg::ST_WDATA;
              end
            endcase
          end
        end
      end
      debug_port_pkg::ST_WDATA: begin
        if (ck_rise) begin
          next_shift = word;
          next_cnt   = cnt + 4'h1;
          if (cnt == debug_port_pkg::BYTE_BITS - 4'h1) begin
            next_state = debug_port_pkg::ST_IDLE;
            if (ins == debug_port_pkg::INS_ADDR_WRITE) begin
              next_selector   = word;
              next_cmd.target = decode_target(word);
            end else if (is_external(data_cmd.target)) begin
              next_cmd.wr    = 1'b1;
              next_cmd.wdata = word;
            end
          end
        end
      end
      debug_port_pkg::ST_RDATA: begin
        if (ck_fall) begin
          if (cnt == debug_port_pkg::BYTE_BITS) begin
            next_oe    = 1'b0;
            next_out   = 1'b0;
            next_state = debug_port_pkg::ST_IDLE;
          end else begin
            if (load_ext) begin
              next_out      = device_rdata[0];
              next_shift    = {1'b0, device_rdata[7:1]};
              next_load_ext = 1'b0;
            end else begin
              next_out   = shift[0];
              next_shift = {1'b0, shift[7:1]};
            end
            next_oe  = 1'b1;
            next_cnt = cnt + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state                   <= debug_port_pkg::ST_IDLE;
      cnt                     <= 4'h0;
      ins                     <= 2'h0;
      shift                   <= 8'h00;
      load_ext                <= 1'b0;
      debug_register_selector <= debug_port_pkg::SELECTOR_RESET;
      data_cmd                <= '{debug_port_pkg::TGT_PART_ID, 1'b0, 1'b0, 8'h00};
      debug_data_pin_out      <= 1'b0;
      debug_data_pin_oe       <= 1'b0;
    end else begin
      state                   <= next_state;
      cnt                     <= next_cnt;
      ins                     <= next_ins;
      shift                   <= next_shift;
      load_ext                <= next_load_ext;
      debug_register_selector <= next_selector;
      data_cmd                <= next_cmd;
      debug_data_pin_out      <= next_out;
      debug_data_pin_oe       <= next_oe;
    end
  end

endmodule // debug_port_address_select

`default_nettype wire

//--- tb/debug_port_address_select_checker.sv
// Port assertions for the debug port address-select block
`default_nettype none
module debug_port_address_select_checker (
  input wire logic                      clk_sys,
  input wire logic                      resetn,
  input wire logic                      debug_clock_pin,
  input wire logic                      debug_data_pin_out,
  input wire logic                      debug_data_pin_oe,
  input wire logic [7:0]                debug_register_selector,
  input wire debug_port_pkg::data_cmd_t data_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_answer_held;
    debug_data_pin_oe [*8];
  endsequence
  a_wr_pulse: assert property (data_cmd.wr |=> !data_cmd.wr && !data_cmd.rd)
    else $error("write pulse too long");
  a_rd_pulse: assert property (data_cmd.rd |=> !data_cmd.rd)
    else $error("read pulse too long");
  a_wr_refused: assert property (data_cmd.wr |-> data_cmd.target > 4'h2)
    else $error("write toward a refused target");
  a_rd_refused: assert property (data_cmd.rd |-> data_cmd.target > 4'h2)
    else $error("read pulse toward an internal target");
  a_wr_after_rise: assert property (data_cmd.wr |-> $past(debug_clock_pin, 2))
    else $error("write pulse without link clock rise");
  a_sel_on_write: assert property (
    $changed(debug_register_selector) |-> !debug_data_pin_oe && $past(debug_clock_pin, 2))
    else $error("selector changed outside a write");
  a_pins_on_fall: assert property (
    $changed({debug_data_pin_out, debug_data_pin_oe}) |-> !debug_clock_pin)
    else $error("data pin changed while link clock high");
  a_answer_held: assert property ($rose(debug_data_pin_oe) |-> s_answer_held)
    else $error("answer not held");
  a_rd_drives: assert property (data_cmd.rd |-> ##[1:20] debug_data_pin_oe)
    else $error("no answer after data read");
endmodule // debug_port_address_select_checker
bind debug_port_address_select debug_port_address_select_checker chk (
  .clk_sys(clk_sys), .resetn(resetn), .debug_clock_pin(debug_clock_pin),
  .debug_data_pin_out(debug_data_pin_out), .debug_data_pin_oe(debug_data_pin_oe),
  .debug_register_selector(debug_register_selector), .data_cmd(data_cmd));
`default_nettype wire

//--- tb/prog_model.sv
// Programmer model: drives link clock and data, reads answers
`default_nettype none
module prog_model (
  output logic      lck,
  output logic      ldat,
  input  wire logic lwire
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {lck, ldat} = 2'b00;
  task automatic bit_out(input logic d);
    ldat = d;
    #40 lck = 1'b1;
    #40 lck = 1'b0;
  endtask
  task automatic frame(input logic [1:0] ins, input logic [7:0] wv, output logic [7:0] rv);
    #1.3;
    rv = 8'h00;
    bit_out(1'b1);
    bit_out(ins[0]);
    bit_out(ins[1]);
    for (int i = 0; i < 8; i++) begin
      if (ins[0]) begin
        bit_out(wv[i]);
      end else begin
        ldat = ~ldat;
        #40 rv[i] = lwire;
        lck = 1'b1;
        #40 lck = 1'b0;
      end
    end
    ldat = 1'b0;
    #120;
  endtask
  task automatic poll_idle(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      frame(2'h2, 8'h00, s);
      ok = !s[7];
    end
  endtask
endmodule // prog_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the debug port address-select block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                      clk_sys = 1'b0;
  logic                      resetn = 1'b0;
  logic                      prog_busy = 1'b0;
  logic [7:0]                device_rdata = 8'h00;
  logic                      lck, ldat, dout, doe, dwire;
  logic [7:0]                sel;
  debug_port_pkg::data_cmd_t cmd;
  int                        err_total = 0, checked = 0, wr_n = 0, rd_n = 0;
  logic [7:0]                sels [12] = '{8'h00, 8'h01, 8'h02, 8'hdf, 8'hbf, 8'hb7,
    8'haf, 8'hae, 8'ha9, 8'haa, 8'hab, 8'hac};
  // ----------
  // Harness
  // ----------
  assign dwire = doe ? dout : ldat;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) wr_n <= wr_n + int'(cmd.wr !== 1'b0);
  always @(posedge clk_sys) rd_n <= rd_n + int'(cmd.rd !== 1'b0);
  debug_port_address_select uut (
    .clk_sys(clk_sys), .resetn(resetn), .debug_clock_pin(lck), .debug_data_pin_in(dwire),
    .prog_busy(prog_busy), .device_rdata(device_rdata), .debug_data_pin_out(dout),
    .debug_data_pin_oe(doe), .debug_register_selector(sel), .data_cmd(cmd));
  prog_model prog (.lck(lck), .ldat(ldat), .lwire(dwire));
  function automatic logic [7:0] exp_read(int i, logic [7:0] dev);
    if (i < 2) return i ? debug_port_pkg::REV_ID_VALUE : debug_port_pkg::PART_ID_VALUE;
    return (i < 12) ? dev : 8'h00;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic one_sel(input int i, input logic [7:0] s);
    logic [7:0] r, v;
    int         w0, r0;
    bit         ext;
    ext = (i > 1 && i < 12);
    v = 8'($urandom);
    prog.frame(2'h3, s, r);
    chk("selector", s, sel);
    chk("target", 8'((i < 12) ? i + 1 : 0), {4'h0, cmd.target});
    w0 = wr_n;
    prog.frame(2'h1, v, r);
    chk("write pulses", 8'(ext), 8'(wr_n - w0));
    if (ext) chk("write data", v, cmd.wdata);
    @(negedge clk_sys) device_rdata = 8'($urandom);
    r0 = rd_n;
    prog.frame(2'h0, 8'h00, r);
    chk("read data", exp_read(i, device_rdata), r);
    chk("read pulses", 8'(ext), 8'(rd_n - r0));
  endtask
  initial begin
    logic [7:0] s, r;
    logic       ok;
    int         i;
    s = 8'($urandom(32'h1faa678e));
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("reset selector", 8'h00, sel);
    chk("reset target", 8'h01, {4'h0, cmd.target});
    chk("reset pins", 8'h00, {6'h00, doe, dout});
    for (int k = 0; k < 12; k++) one_sel(k, sels[k]);
    for (int k = 0; k < 10; k++) begin
      i = (k < 3) ? 12 : int'($urandom_range(12));
      s = (i < 12) ? sels[i] : (k == 0) ? 8'ha8 : (k == 1) ? 8'had : {2'b01, 6'($urandom)};
      one_sel(i, s);
    end
    @(negedge clk_sys) prog_busy = 1'b1;
    prog.frame(2'h2, 8'h00, r);
    chk("busy flag", 8'h80, {r[7], 7'h00});
    fork
      #3000 @(negedge clk_sys) prog_busy = 1'b0;
      prog.poll_idle(ok);
    join
    chk("busy cleared", 8'h01, {7'h00, ok});
    prog.frame(2'h3, 8'hdf, r);
    chk("selector before reset", 8'hdf, sel);
    @(negedge clk_sys) resetn = 1'b0;
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("second reset selector", 8'h00, sel);
    prog.frame(2'h0, 8'h00, r);
    chk("read after reset", debug_port_pkg::PART_ID_VALUE, r);
    close_out();
  end
  initial begin
    #300000;
    err_total++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
